/* rtl/tape_consts.vh */
// Constants for the tape error and status flag logic
`ifndef TAPE_CONSTS_VH
`define TAPE_CONSTS_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFF_STATUS 8'h00
`define OFF_CMD 8'h04
`define OFF_CHAR 8'h08

// ----------------------------------------
// Status field positions
// ----------------------------------------
`define ST_EOF 14
`define ST_CRC 13
`define ST_PAR 12
`define ST_GRANT_LATE 11
`define ST_CLIPOFF 3
`define ST_BUSY 2
`define ST_WRITE_READY 1
`define ST_DMA 0

// ----------------------------------------
// Command field positions, codes, reset value
// ----------------------------------------
`define CMD_GO 0
`define CMD_FN_LO 1
`define CMD_FN_HI 3
`define CMD_EVEN 4
`define CMD_ACI 5
`define CMD_IE 6
`define CMD_ERR 15
`define CMD_RESET 16'h0000
`define FN_READ 3'h1
`define FN_WRITE 3'h2
`define FN_WEOF 3'h3
`define FN_WGAP 3'h4

// ----------------------------------------
// Timing
// ----------------------------------------
`define PEAK_PULSE_NS 300
`define CLK_PERIOD_NS 8
`define PEAK_PULSE_CYC ((`PEAK_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define REREAD_W 3

`endif

/* rtl/pin_sync3.v */
// Three-stage synchroniser with agreement filter for pin inputs
`timescale 1ns/1ps
`default_nettype none

module pin_sync3 #(
  parameter W = 1
) (
  // Clock and reset
  input wire clk_sys,
  input wire rst,
  // Raw pins and filtered result
  input wire [W-1:0] d,
  output reg [W-1:0] q
);

  reg [W-1:0] ff1;
  reg [W-1:0] ff2;
  reg [W-1:0] ff3;
  wire [W-1:0] agree;

  // Only stages two and three are compared; stage one feeds stage two alone
  assign agree = ~(ff2 ^ ff3);

  // Shift chain, output follows once the last two stages agree
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ff1 <= {W{1'b0}};
      ff2 <= {W{1'b0}};
      ff3 <= {W{1'b0}};
      q <= {W{1'b0}};
    end else begin
      ff1 <= d;
      ff2 <= ff1;
      ff3 <= ff2;
      q <= (ff3 & agree) | (q & ~agree);
    end
  end

endmodule // pin_sync3

`default_nettype wire

/* rtl/peak_pulse.v */
// One read channel peak qualifier: fixed-width pulse per analog peak
`timescale 1ns/1ps
`default_nettype none

module peak_pulse #(
  parameter CW = 8,
  parameter [CW-1:0] PW = 8'd38
) (
  // Clock and reset
  input wire clk_sys,
  input wire rst,
  // Synchronised amplifier level, pulse out
  input wire amp_level,
  output reg pulse
);

  reg amp_d;
  reg [CW-1:0] cnt;
  wire peak_edge;

  // Amplifier output falls at the analog peak
  assign peak_edge = amp_d & ~amp_level;

  // Pulse timer; edges seen while it runs are dropped, so noise cannot retrigger
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      amp_d <= 1'b0;
      cnt <= {CW{1'b0}};
      pulse <= 1'b0;
    end else begin
      amp_d <= amp_level;
      if (cnt != {CW{1'b0}}) begin
        cnt <= cnt - 1'b1;
        if (cnt == {{(CW-1){1'b0}}, 1'b1})
          pulse <= 1'b0;
      end else if (peak_edge) begin
        cnt <= PW;
        pulse <= 1'b1;
      end
    end
  end

endmodule // peak_pulse

`default_nettype wire

/* rtl/tape_error_status_logic.v */
// Tape controller error/status flags, DMA request, clipping and peak logic
//
// The APB register port and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "tape_consts.vh"

module tape_error_status_logic #(
  parameter NCHAN = 9
) (
  // Clock and reset
  input wire clk_sys,
  input wire rst,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // Host bus side
  input wire bus_init,
  input wire dma_done_clear,
  output reg dma_request_trigger,
  output reg dma_request_pending,
  output wire fault_irq,
  // Transport status pins
  input wire file_mark_seen,
  input wire crc_compare_error,
  input wire longitudinal_char_seen,
  input wire char_parity_error,
  input wire longitudinal_check_error,
  input wire read_strobe,
  input wire write_strobe_pulse,
  input wire write_ready,
  input wire transport_busy_n,
  // Read amplifier channels
  input wire [NCHAN-1:0] amp_out,
  output wire [NCHAN-1:0] peak_out,
  output wire peak_any,
  output reg [NCHAN-1:0] char_data,
  // Clipping control and mode
  output wire clip_normal_sel,
  output wire clip_high_sel,
  output wire write_enabled
);

  // ----------------------------------------
  // Pin synchronisation
  // ----------------------------------------

  localparam NPIN = 10;
  localparam integer PW = `PEAK_PULSE_CYC;

  wire [NPIN+NCHAN-1:0] raw_pins;
  wire [NPIN+NCHAN-1:0] sync_pins;
  wire init_s;
  wire fmark_s;
  wire crc_err_s;
  wire lcs_s;
  wire cpe_s;
  wire lce_s;
  wire rd_strobe_s;
  wire wr_strobe_s;
  wire wr_ready_s;
  wire busy_n_s;
  wire [NCHAN-1:0] amp_s;

  // All asynchronous pins share one filtered synchroniser bank
  assign raw_pins = {amp_out, transport_busy_n, write_ready, write_strobe_pulse,
                     read_strobe, longitudinal_check_error, char_parity_error,
                     longitudinal_char_seen, crc_compare_error, file_mark_seen,
                     bus_init};

  pin_sync3 #(
    .W(NPIN + NCHAN)
  ) u_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .d(raw_pins),
    .q(sync_pins)
  );

  // Unpack filtered pins
  assign init_s = sync_pins[0];
  assign fmark_s = sync_pins[1];
  assign crc_err_s = sync_pins[2];
  assign lcs_s = sync_pins[3];
  assign cpe_s = sync_pins[4];
  assign lce_s = sync_pins[5];
  assign rd_strobe_s = sync_pins[6];
  assign wr_strobe_s = sync_pins[7];
  assign wr_ready_s = sync_pins[8];
  assign busy_n_s = sync_pins[9];
  assign amp_s = sync_pins[NPIN+NCHAN-1:NPIN];

  // ----------------------------------------
  // Register state declarations
  // ----------------------------------------
  reg [15:0] cmd;
  reg go_pulse;
  reg eof_flag;
  reg crc_mismatch_flag;
  reg parity_fault_flag;
  reg grant_late_flag;
  reg fault_summary;
  reg rd_strobe_d;
  reg wr_strobe_d;
  reg [NCHAN-1:0] char_latch;
  reg [1:0] clip_state;
  reg [`REREAD_W-1:0] reread_cnt;

  // ----------------------------------------
  // APB decode
  // ----------------------------------------

  wire apb_setup;
  wire apb_access;
  wire apb_wr;
  wire hit_status;
  wire hit_cmd;
  wire hit_char;
  wire mapped;

  // Decode shared by read mux and error answer
  function addr_is;
    input [7:0] a;
    input [7:0] off;
    begin
      addr_is = (a == off);
    end
  endfunction

  assign apb_setup = psel & ~penable;
  assign apb_access = psel & penable;
  assign hit_status = addr_is(paddr, `OFF_STATUS);
  assign hit_cmd = addr_is(paddr, `OFF_CMD);
  assign hit_char = addr_is(paddr, `OFF_CHAR);
  assign mapped = hit_status | hit_cmd | hit_char;
  assign apb_wr = apb_access & pwrite;

  // Zero wait states; read data is loaded in the setup cycle
  assign pready = 1'b1;
  assign pslverr = apb_access & ~mapped;

  // ----------------------------------------
  // Mode decode
  // ----------------------------------------

  wire [2:0] fn;
  wire read_active;
  wire even_parity_select;
  wire auto_clip_inhibit;
  wire flag_clear;

  assign fn = cmd[`CMD_FN_HI:`CMD_FN_LO];
  assign read_active = (fn == `FN_READ);
  // Write, write file mark and extended-gap write all count as writing
  assign write_enabled = (fn == `FN_WRITE) | (fn == `FN_WEOF) | (fn == `FN_WGAP);
  assign even_parity_select = cmd[`CMD_EVEN];
  assign auto_clip_inhibit = cmd[`CMD_ACI];
  assign flag_clear = init_s | go_pulse;

  // ----------------------------------------
  // Status and command words
  // ----------------------------------------

  wire auto_clip_off;
  wire [15:0] status_word;
  wire [15:0] cmd_word;

  assign status_word = {1'b0, eof_flag, crc_mismatch_flag, parity_fault_flag,
                        grant_late_flag, 7'h00, auto_clip_off, ~busy_n_s,
                        wr_ready_s, dma_request_pending};
  assign cmd_word = {fault_summary, cmd[14:1], 1'b0};

  // Read mux, registered in setup so data stands through access
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      prdata <= 32'h00000000;
    end else if (apb_setup) begin
      if (hit_status)
        prdata <= {16'h0000, status_word};
      else if (hit_cmd)
        prdata <= {16'h0000, cmd_word};
      else if (hit_char)
        prdata <= {{(32-NCHAN){1'b0}}, char_latch};
      else
        prdata <= 32'h00000000;
    end
  end

  // ----------------------------------------
  // Command register and go pulse
  // ----------------------------------------

  // Go bit is self-clearing; it yields a one-cycle pulse after the write
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cmd <= `CMD_RESET;
      go_pulse <= 1'b0;
    end else begin
      go_pulse <= 1'b0;
      if (init_s) begin
        cmd <= `CMD_RESET;
      end else if (apb_wr && hit_cmd) begin
        cmd <= {1'b0, pwdata[14:1], 1'b0};
        go_pulse <= pwdata[`CMD_GO];
      end
    end
  end

  // ----------------------------------------
  // Strobe edges and DMA request
  // ----------------------------------------

  wire rd_strobe_rise;
  wire wr_strobe_rise;
  wire trig_event;

  assign rd_strobe_rise = rd_strobe_s & ~rd_strobe_d;
  assign wr_strobe_rise = wr_strobe_s & ~wr_strobe_d;
  assign trig_event = rd_strobe_rise | wr_strobe_rise;

  // Strobe edge history
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rd_strobe_d <= 1'b0;
      wr_strobe_d <= 1'b0;
    end else begin
      rd_strobe_d <= rd_strobe_s;
      wr_strobe_d <= wr_strobe_s;
    end
  end

  // Trigger is one cycle wide; the request sets as it falls.
  // A set in the same cycle as the done-clear wins, so no request is lost.
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      dma_request_trigger <= 1'b0;
      dma_request_pending <= 1'b0;
    end else begin
      dma_request_trigger <= trig_event;
      if (dma_request_trigger)
        dma_request_pending <= 1'b1;
      else if (dma_done_clear || init_s)
        dma_request_pending <= 1'b0;
    end
  end

  // ----------------------------------------
  // Error flags
  // ----------------------------------------

  wire vert_bad;
  wire par_event;
  wire summary_set;

  // Vertical parity of the assembled character against the chosen sense
  assign vert_bad = even_parity_select ? (^char_data) : ~(^char_data);
  // Each read-strobed character is checked while a read or write function is set, CRC and check characters included
  assign par_event = rd_strobe_rise & (read_active | write_enabled) &
                     (cpe_s | lce_s | vert_bad);
  // Summary is deferred until the check character so the record can finish
  assign summary_set = lcs_s & (crc_mismatch_flag | parity_fault_flag);

  // Sticky flags; a set in the clearing cycle wins
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      eof_flag <= 1'b0;
      crc_mismatch_flag <= 1'b0;
      parity_fault_flag <= 1'b0;
      grant_late_flag <= 1'b0;
      fault_summary <= 1'b0;
    end else begin
      if (fmark_s)
        eof_flag <= 1'b1;
      else if (flag_clear)
        eof_flag <= 1'b0;
      if (crc_err_s)
        crc_mismatch_flag <= 1'b1;
      else if (flag_clear)
        crc_mismatch_flag <= 1'b0;
      if (par_event)
        parity_fault_flag <= 1'b1;
      else if (flag_clear)
        parity_fault_flag <= 1'b0;
      if (dma_request_trigger && dma_request_pending)
        grant_late_flag <= 1'b1;
      else if (flag_clear)
        grant_late_flag <= 1'b0;
      if (summary_set)
        fault_summary <= 1'b1;
      else if (flag_clear)
        fault_summary <= 1'b0;
    end
  end

  // Interrupt request follows the summary when enabled
  assign fault_irq = fault_summary & cmd[`CMD_IE];

  // ----------------------------------------
  // Peak qualification per channel
  // ----------------------------------------

  genvar ch;
  generate
    for (ch = 0; ch < NCHAN; ch = ch + 1) begin : g_chan
      peak_pulse #(
        .CW(8),
        .PW(PW[7:0])
      ) u_peak (
        .clk_sys(clk_sys),
        .rst(rst),
        .amp_level(amp_s[ch]),
        .pulse(peak_out[ch])
      );
    end
  endgenerate

  // Combined pulse feeds deskew and read strobe timing
  assign peak_any = |peak_out;

  // ----------------------------------------
  // Character data flip-flops
  // ----------------------------------------

  // Peaks record ones; each read strobe latches the character and empties
  // the flip-flops. A peak arriving with the strobe belongs to the next one.
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      char_data <= {NCHAN{1'b0}};
      char_latch <= {NCHAN{1'b0}};
    end else if (rd_strobe_rise) begin
      char_latch <= char_data;
      char_data <= peak_out;
    end else begin
      char_data <= char_data | peak_out;
    end
  end

  // ----------------------------------------
  // Automatic clipping level control
  // ----------------------------------------

  // Disabled during read-after-write, on inhibit, or while transport busy
  assign auto_clip_off = wr_ready_s | auto_clip_inhibit | ~busy_n_s;

  // State flip-flops held set and reread counter held clear while disabled.
  // When enabled, each parity fault counts a reread, saturating at 7, and steps the state down.
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      clip_state <= 2'b11;
      reread_cnt <= {`REREAD_W{1'b0}};
    end else if (auto_clip_off) begin
      clip_state <= 2'b11;
      reread_cnt <= {`REREAD_W{1'b0}};
    end else if (par_event) begin
      clip_state <= {clip_state[0], 1'b0};
      if (reread_cnt != {`REREAD_W{1'b1}})
        reread_cnt <= reread_cnt + 1'b1;
    end
  end

  // Both selects together give the highest level in read-after-write
  assign clip_normal_sel = wr_ready_s | (reread_cnt == {`REREAD_W{1'b0}});
  assign clip_high_sel = wr_ready_s | ~clip_state[1];
endmodule // tape_error_status_logic

`default_nettype wire

/* sim/tape_error_status_logic_assertions.sv */
// Port-level assertions for the tape error and status flag block
`timescale 1ns/1ps
`default_nettype none
module tape_esl_checker #(
  parameter NCHAN = 9
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Host side
  input wire logic dma_done_clear,
  input wire logic dma_request_trigger,
  input wire logic dma_request_pending,
  // Transport side
  input wire logic read_strobe,
  input wire logic write_strobe_pulse,
  input wire logic write_ready,
  input wire logic transport_busy_n,
  input wire logic [NCHAN-1:0] peak_out,
  input wire logic peak_any,
  input wire logic [NCHAN-1:0] char_data,
  input wire logic clip_normal_sel,
  input wire logic clip_high_sel
);
  logic [7:0] hi_cnt;
  // Channel 0 pulse length; a repetition this long would crawl
  always @(posedge clk_sys or posedge rst) begin
    if (rst) hi_cnt <= 8'h00;
    else if (peak_out[0]) hi_cnt <= hi_cnt + 8'h01;
    else hi_cnt <= 8'h00;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence s_strobe;
    $rose(read_strobe) || $rose(write_strobe_pulse);
  endsequence
  sequence s_trig;
    dma_request_trigger ##1 !dma_request_trigger;
  endsequence
  property p_trigger;
    s_strobe |-> ##[2:7] s_trig;
  endproperty
  a_trigger: assert property (p_trigger) else $error("no trigger pulse");
  property p_pend;
    dma_request_trigger |=> dma_request_pending;
  endproperty
  a_pend: assert property (p_pend) else $error("request not set");
  property p_clear;
    dma_done_clear && !dma_request_trigger |=> !dma_request_pending;
  endproperty
  a_clear: assert property (p_clear) else $error("request not cleared");
  property p_width;
    $fell(peak_out[0]) |-> hi_cnt == 8'h26;
  endproperty
  a_width: assert property (p_width) else $error("peak width wrong");
  property p_any;
    peak_any == (|peak_out);
  endproperty
  a_any: assert property (p_any) else $error("peak or wrong");
  property p_data;
    $rose(peak_out[0]) |-> ##[0:2] char_data[0];
  endproperty
  a_data: assert property (p_data) else $error("data bit not set");
  property p_raw;
    write_ready [*8] |-> clip_normal_sel && clip_high_sel;
  endproperty
  a_raw: assert property (p_raw) else $error("clip sels wrong");
  property p_busy;
    !transport_busy_n [*8] |-> clip_normal_sel;
  endproperty
  a_busy: assert property (p_busy) else $error("counter not held");
endmodule // tape_esl_checker
bind tape_error_status_logic tape_esl_checker #(.NCHAN(NCHAN)) tape_esl_checker_i (.*);
`default_nettype wire

/* sim/tape_transport_model.sv */
// Behavioural transport: read peaks and one data strobe per character
`timescale 1ns/1ps
`default_nettype none
module tape_transport_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Character request
  input wire logic start,
  input wire logic wmode,
  input wire logic [8:0] bits,
  // Transport pins
  output logic [8:0] amp_out,
  output logic read_strobe,
  output logic write_strobe_pulse,
  output logic active
);
  logic [6:0] step;
  assign active = step != 7'h00;
  // Strobe comes well after the peaks so the character is complete
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      step <= 7'h00;
      amp_out <= 9'h1FF;
      read_strobe <= 1'b0;
      write_strobe_pulse <= 1'b0;
    end else begin
      if (step == 7'h3C) step <= 7'h00;
      else if (active || start) step <= step + 7'h01;
      amp_out <= (step > 7'h00 && step < 7'h08) ? ~bits : 9'h1FF;
      read_strobe <= !wmode && step > 7'h32 && step < 7'h3A;
      write_strobe_pulse <= wmode && step > 7'h32 && step < 7'h3A;
    end
  end
endmodule // tape_transport_model
`default_nettype wire

/* sim/tape_error_status_logic_bench.sv */
// Self-checking bench for the tape error and status flag block
`timescale 1ns/1ps
`default_nettype none
`include "tape_consts.vh"
module tape_error_status_logic_bench;
  // ----
  // Signals
  // ----
  logic clk_sys = 0;
  logic rst = 1;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0;
  logic [5:0] pins = 0;
  logic dma_done_clear = 0;
  logic write_ready = 0;
  logic transport_busy_n = 1;
  logic start = 0;
  logic wmode = 0;
  logic [8:0] bits = 0;
  wire [31:0] prdata;
  wire pready, pslverr, dma_request_trigger, dma_request_pending, fault_irq;
  wire read_strobe, write_strobe_pulse, active, peak_any;
  wire clip_normal_sel, clip_high_sel, write_enabled;
  wire [8:0] amp_out, peak_out, char_data;
  int err_total = 0;
  int samples_checked = 0;
  int cyc = 0;
  logic [31:0] rd;
  logic perr;
  tape_error_status_logic tape_error_status_logic_i (.*, .bus_init(pins[5]),
    .file_mark_seen(pins[0]), .crc_compare_error(pins[1]),
    .longitudinal_char_seen(pins[2]), .char_parity_error(pins[3]),
    .longitudinal_check_error(pins[4]));
  tape_transport_model tape_transport_model_i (.*);
  // Clock and hang guard
  always #4 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      conclude;
    end
  end
  // ----
  // Shared tasks
  // ----
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task conclude;
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Pins pass a 3-4 cycle filter, so hold and settle for 6 each
  task pin(input int k);
    pins[k] <= 1'b1;
    repeat (6) @(posedge clk_sys);
    pins[k] <= 1'b0;
    repeat (6) @(posedge clk_sys);
  endtask
  task st(input logic [31:0] m, input logic [31:0] e, input string n);
    apb(1'b0, `OFF_STATUS, 32'h0);
    chk(n, rd & m, e);
  endtask
  task go(input logic [31:0] c);
    apb(1'b1, `OFF_CMD, c | 32'h1);
    repeat (2) @(posedge clk_sys);
  endtask
  task xfer(input logic w, input logic [8:0] b);
    wmode <= w;
    bits <= b;
    start <= 1'b1;
    @(posedge clk_sys);
    start <= 1'b0;
    @(posedge clk_sys);
    while (active) @(posedge clk_sys);
    repeat (8) @(posedge clk_sys);
  endtask
  // ----
  // Scenarios
  // ----
  task s_reset;
    st(32'hFFFFFFFF, 0, "status rst");
    apb(1'b0, `OFF_CMD, 0);
    chk("cmd rst", rd, `CMD_RESET);
    apb(1'b1, 8'h0C, 32'hFFFF);
    chk("unmapped err", perr, 1);
    apb(1'b0, 8'h0C, 0);
    chk("unmapped rd", rd, 0);
    apb(1'b1, `OFF_STATUS, 32'hFFFF);
    st(32'hFFFFFFFF, 0, "status ro");
  endtask
  task s_eof;
    pin(0);
    st(32'h4000, 32'h4000, "eof set");
    go(0);
    st(32'h4000, 0, "eof go");
    pin(0);
    pin(5);
    st(32'h4000, 0, "eof init");
  endtask
  task s_crc;
    apb(1'b1, `OFF_CMD, 32'h40);
    pin(1);
    st(32'h2000, 32'h2000, "crc set");
    apb(1'b0, `OFF_CMD, 0);
    chk("summary early", {rd[15], fault_irq}, 0);
    pin(2);
    apb(1'b0, `OFF_CMD, 0);
    chk("summary late", {rd[15], fault_irq}, 2'b11);
    go(32'h40);
    st(32'h2000, 0, "crc go");
    pin(1);
    pin(2);
    pin(5);
    st(32'h2000, 0, "crc init");
    apb(1'b0, `OFF_CMD, 0);
    chk("irq init", {rd[15], fault_irq}, 0);
  endtask
  // Every function code, external errors on both inputs, then the sense bit
  task s_par;
    for (int f = 0; f < 5; f++) begin
      apb(1'b1, `OFF_CMD, f << 1);
      pins[f == 1 ? 4 : 3] <= 1'b1;
      xfer(0, 9'h001);
      pins <= 6'h00;
      chk("write mode", write_enabled, f >= 2);
      st(32'h1000, f ? 32'h1000 : 0, "parity");
      apb(1'b0, `OFF_CMD, 0);
      chk("summary", rd[15], 0);
      go(f << 1);
    end
    apb(1'b1, `OFF_CMD, 32'h02);
    xfer(0, 9'h001);
    st(32'h1000, 0, "odd sense");
    apb(1'b0, `OFF_CHAR, 0);
    chk("char", rd, 32'h001);
    apb(1'b1, `OFF_CMD, 32'h12);
    xfer(0, 9'h001);
    st(32'h1000, 32'h1000, "even sense");
    chk("clip count", clip_normal_sel, 0);
    pin(2);
    apb(1'b0, `OFF_CMD, 0);
    chk("summary par", rd[15], 1);
    apb(1'b1, `OFF_CMD, 32'h20);
    repeat (2) @(posedge clk_sys);
    chk("inhibit", clip_normal_sel, 1);
    pin(5);
  endtask
  task s_clip;
    transport_busy_n <= 1'b0;
    repeat (8) @(posedge clk_sys);
    st(32'h0C, 32'h0C, "busy");
    transport_busy_n <= 1'b1;
    write_ready <= 1'b1;
    repeat (8) @(posedge clk_sys);
    chk("sels", {clip_normal_sel, clip_high_sel}, 2'b11);
    st(32'h0A, 32'h0A, "write_ready");
    write_ready <= 1'b0;
  endtask
  task s_dma;
    xfer(1, 9'h000);
    chk("pend", dma_request_pending, 1);
    st(32'h800, 0, "late clear");
    xfer(1, 9'h000);
    st(32'h800, 32'h800, "late set");
    dma_done_clear <= 1'b1;
    @(posedge clk_sys);
    dma_done_clear <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk("pend off", dma_request_pending, 0);
    go(0);
    st(32'h800, 0, "late go");
  endtask
  // Main sequence
  initial begin
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    // Busy pin idles high but its synchroniser starts at zero; let it settle
    repeat (6) @(posedge clk_sys);
    s_reset;
    s_eof;
    s_crc;
    s_par;
    s_clip;
    s_dma;
    conclude;
  end
endmodule // tape_error_status_logic_bench
`default_nettype wire
